//--- logic/wlal_top.sv
`timescale 1ns/1ps

// Overview of operation
// - latched flags stay set until an accepted fault clear command clears all those whose source is gone
// - flags 10, 11 and 13 clear themselves once their condition is gone
// - bit 0 marks any general warning; its code is kept separately
// - bit 1 power stage temperature high, bit 2 motor temperature high
// - overload bits: 4 power stage, 5 motor, 6 braking resistor
// - communication bits: 7 CAN, 9 RS485, 12 second fieldbus
// - bit 8 set on a motor encoder warning
// - bit 10 set when either power stage ready input warns
// - bit 11 set on DC bus undervoltage or missing mains phase
// - bit 13 set while position detection is still running
// - only bit 13 depends on the active control mode; other modes hold it low
// - lock value 0 opens other channels, value 1 blocks them
// - fieldbus master sets lock; tool, panel, second fieldbus writes then refused
// - digital inputs such as stop are processed regardless of the lock
// - active warning word mirrors present conditions with the same bit map
module wlal_top (
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  input  wire wlal_pkg::wlal_warn_src_t warn_src_i,
  input  wire logic [15:0]             general_code_i,
  input  wire wlal_pkg::wlal_mode_t    mode_i,
  input  wire logic                    fault_clear_command_i,
  input  wire wlal_pkg::wlal_chan_t    fault_clear_chan_i,
  input  wire wlal_pkg::wlal_req_t     req_i,
  input  wire logic                    stop_i,
  output logic                         stop_o,
  output wlal_pkg::wlal_rsp_t          rsp_o,
  output logic [15:0]                  active_warning_word_o,
  output logic [15:0]                  latched_warning_word_o,
  output logic [15:0]                  last_warning_code_o,
  output logic                         channel_lock_o
);
  import wlal_pkg::*;

  // timing at a glance
  // every source is a level and is sampled on each rising edge
  // the active word shows the sources one cycle later
  // the latched word sets in the same cycle as the active word
  // sticky bits then hold until an accepted fault clear
  // self clearing bits need the active copy low for one more edge
  // so they drop two edges after their source goes away
  // that extra edge filters a single quiet sample on a noisy source
  // a fault clear with a source still high keeps that bit set
  // so a warning that is present is never hidden by a clear
  // the last warning code is not touched by a fault clear
  // so the cause of bit 0 stays readable after the word is emptied
  //
  // register access
  // one request per valid cycle, back to back allowed
  // the answer comes on the next edge and stands for one cycle
  // reads are never blocked, from any channel
  // writes from a shut out channel answer refused and store nothing
  // writes to unknown or read-only words answer with the error flag
  // the lock takes only values zero and one, only from the master
  // anything else on the lock answers error and leaves it unchanged
  //
  // limitations
  // the live word is one cycle behind the sources by design
  // a user polling both words sees them in step, not the raw pins
  // only the position wait bit depends on the control mode
  // all other bits keep one meaning in every mode
  // reserved bits read zero in both words whatever the sources do
  //
  // trade-offs
  // the answer is registered so the read data comes from flip-flops
  // this costs one cycle of latency on every access
  // a fault clear is treated as an active access for the lock
  // so a shut out channel cannot empty the master's warning view
  // the stop path is a plain register and never sees the lock
  //
  // state held here
  // lock value, latched word, live word, last code, stop copy
  // and the registered answer
  //
  // nothing else is remembered between accesses

  // channel lock value as written by the master
  logic [15:0] lock_ff;
  logic [15:0] latched_ff;
  logic [15:0] nxt_latched;
  logic [15:0] active_ff;
  logic [15:0] nxt_active;
  logic [15:0] code_ff;
  logic        stop_ff;
  wlal_rsp_t   rsp_ff;
  wlal_rsp_t   nxt_rsp;
  logic        clear_ok;
  logic        lock_wr;

  // a channel other than the fieldbus master is shut out while the lock holds
  function automatic logic chan_blocked(input logic [15:0] lock, input wlal_chan_t ch);
    chan_blocked = (lock == LOCK_SHUT) && (ch != WLAL_CH_FIELDBUS);
  endfunction

  // true when the request addresses a known register
  function automatic logic addr_known(input logic [15:0] a);
    addr_known = (a == ADDR_LOCK) || (a == ADDR_ACTIVE) || (a == ADDR_LATCHED);
  endfunction

  // map present conditions onto warning bits for the selected control mode
  always_comb begin
    nxt_active = WARN_RESET;
    nxt_active[BIT_GENERAL]    = warn_src_i.general;
    nxt_active[BIT_STAGE_TEMP] = warn_src_i.stage_temp;
    nxt_active[BIT_MOTOR_TEMP] = warn_src_i.motor_temp;
    nxt_active[BIT_STAGE_OVL]  = warn_src_i.stage_ovl;
    nxt_active[BIT_MOTOR_OVL]  = warn_src_i.motor_ovl;
    nxt_active[BIT_BRAKE_OVL]  = warn_src_i.brake_ovl;
    nxt_active[BIT_CAN]        = warn_src_i.can;
    nxt_active[BIT_RS485]      = warn_src_i.rs485;
    nxt_active[BIT_FIELDBUS2]  = warn_src_i.fieldbus2;
    nxt_active[BIT_ENCODER]    = warn_src_i.encoder;
    nxt_active[BIT_READY]      = warn_src_i.power_stage_ready_a |
                                 warn_src_i.power_stage_ready_b;
    nxt_active[BIT_SUPPLY]     = warn_src_i.undervolt | warn_src_i.phase_loss;
    case (mode_i)
      WLAL_MODE_POSITION: begin
        nxt_active[BIT_POS_WAIT] = warn_src_i.pos_pending;
      end
      // speed control runs without an absolute position
      WLAL_MODE_SPEED: begin
        nxt_active[BIT_POS_WAIT] = 1'b0;
      end
      // current control runs without an absolute position
      WLAL_MODE_CURRENT: begin
        nxt_active[BIT_POS_WAIT] = 1'b0;
      end
      // other modes treat the position as not needed
      WLAL_MODE_OTHER: begin
        nxt_active[BIT_POS_WAIT] = 1'b0;
      end
      // any mode encoding not named above needs no valid position, so no warning
      default: begin
        nxt_active[BIT_POS_WAIT] = 1'b0;
      end
    endcase
  end

  // non-sticky word, registered so it lines up with the latched word
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      active_ff <= WARN_RESET;
    end else begin
      active_ff <= nxt_active;
    end
  end

  // a fault clear from a locked-out channel is an active access and is ignored
  assign clear_ok = fault_clear_command_i && !chan_blocked(lock_ff, fault_clear_chan_i);

  // per-bit latch; a new warning in the clear cycle wins so it is never lost
  // reserved positions are tied low so they can never latch
  // self clearing positions also need the live copy high to hold
  // sticky positions hold until an accepted clear
  for (genvar i = 0; i < WORD_W; i++) begin : g_latch
    if (RESERVED_MASK[i]) begin : g_rsvd
      assign nxt_latched[i] = 1'b0;
    end else if (AUTO_CLR_MASK[i]) begin : g_auto
      assign nxt_latched[i] = nxt_active[i] | (latched_ff[i] & active_ff[i] & !clear_ok);
    end else begin : g_sticky
      assign nxt_latched[i] = nxt_active[i] | (latched_ff[i] & !clear_ok);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latched_ff <= WARN_RESET;
    end else begin
      latched_ff <= nxt_latched;
    end
  end

  // identity of the most recent general warning, kept across fault clears
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      code_ff <= CODE_RESET;
    end else if (warn_src_i.general) begin
      code_ff <= general_code_i;
    end
  end

  // only the fieldbus master may change the lock, and only to a legal value
  // an illegal value is refused whole so the lock never holds a third state
  assign lock_wr = req_i.valid && req_i.write && (req_i.addr == ADDR_LOCK) &&
                   (req_i.chan == WLAL_CH_FIELDBUS) && (req_i.wdata <= LOCK_SHUT);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_ff <= LOCK_RESET;
    end else if (lock_wr) begin
      lock_ff <= req_i.wdata;
    end
  end

  // answer every request one cycle later; reads stay open to all channels
  // the refused check comes first so a blocked write never reports error
  // read data is zero on any answer that is not a good read
  always_comb begin
    nxt_rsp = '0;
    nxt_rsp.valid = req_i.valid;
    if (req_i.valid) begin
      if (req_i.write && chan_blocked(lock_ff, req_i.chan)) begin
        nxt_rsp.refused = 1'b1;
      end else if (!addr_known(req_i.addr)) begin
        nxt_rsp.err = 1'b1;
      end else if (req_i.write) begin
        // read-only words, foreign lock writes and out-of-range values fail
        nxt_rsp.err = !lock_wr;
      end else begin
        case (req_i.addr)
          ADDR_LOCK:    nxt_rsp.rdata = lock_ff;
          ADDR_ACTIVE:  nxt_rsp.rdata = active_ff;
          ADDR_LATCHED: nxt_rsp.rdata = latched_ff;
          default:      nxt_rsp.rdata = WARN_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  // stop input path never looks at the lock
  // keeping it apart means a lock mistake cannot mask a stop request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stop_ff <= 1'b0;
    end else begin
      stop_ff <= stop_i;
    end
  end

  // outputs straight from the registers above
  assign stop_o                 = stop_ff;
  assign rsp_o                  = rsp_ff;
  assign active_warning_word_o  = active_ff;
  assign latched_warning_word_o = latched_ff;
  assign last_warning_code_o    = code_ff;
  assign channel_lock_o         = (lock_ff == LOCK_SHUT);

endmodule

//--- logic/wlal_pkg.sv
package wlal_pkg;

  localparam int WORD_W = 16;

  // register addresses as seen by every access channel
  localparam logic [15:0] ADDR_LOCK    = 16'h013c;
  localparam logic [15:0] ADDR_ACTIVE  = 16'h1c16;
  localparam logic [15:0] ADDR_LATCHED = 16'h1c18;

  // warning bit positions
  localparam int BIT_GENERAL    = 0;
  localparam int BIT_STAGE_TEMP = 1;
  localparam int BIT_MOTOR_TEMP = 2;
  localparam int BIT_STAGE_OVL  = 4;
  localparam int BIT_MOTOR_OVL  = 5;
  localparam int BIT_BRAKE_OVL  = 6;
  localparam int BIT_CAN        = 7;
  localparam int BIT_ENCODER    = 8;
  localparam int BIT_RS485      = 9;
  localparam int BIT_READY      = 10;
  localparam int BIT_SUPPLY     = 11;
  localparam int BIT_FIELDBUS2  = 12;
  localparam int BIT_POS_WAIT   = 13;

  localparam logic [15:0] RESERVED_MASK = 16'hc008;
  localparam logic [15:0] AUTO_CLR_MASK = 16'h2c00;
  localparam logic [15:0] WARN_RESET    = 16'h0000;
  localparam logic [15:0] CODE_RESET    = 16'h0000;

  // channel lock values
  localparam logic [15:0] LOCK_OPEN  = 16'h0000;
  localparam logic [15:0] LOCK_SHUT  = 16'h0001;
  localparam logic [15:0] LOCK_RESET = 16'h0000;

  typedef enum logic [1:0] {
    WLAL_CH_FIELDBUS  = 2'h0,
    WLAL_CH_TOOL      = 2'h1,
    WLAL_CH_PANEL     = 2'h2,
    WLAL_CH_FIELDBUS2 = 2'h3
  } wlal_chan_t;

  typedef enum logic [1:0] {
    WLAL_MODE_POSITION = 2'h0,
    WLAL_MODE_SPEED    = 2'h1,
    WLAL_MODE_CURRENT  = 2'h2,
    WLAL_MODE_OTHER    = 2'h3
  } wlal_mode_t;

  // present warning conditions, all levels
  typedef struct packed {
    logic general;
    logic stage_temp;
    logic motor_temp;
    logic stage_ovl;
    logic motor_ovl;
    logic brake_ovl;
    logic can;
    logic encoder;
    logic rs485;
    logic power_stage_ready_a;
    logic power_stage_ready_b;
    logic undervolt;
    logic phase_loss;
    logic fieldbus2;
    logic pos_pending;
  } wlal_warn_src_t;

  typedef struct packed {
    logic        valid;
    wlal_chan_t  chan;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wlal_req_t;

  typedef struct packed {
    logic        valid;
    logic        refused;
    logic        err;
    logic [15:0] rdata;
  } wlal_rsp_t;

endpackage

//--- dv/wlal_chk_sva.sv
`timescale 1ns/1ps
module wlal_chk
  import wlal_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           srst_i,
  input wire wlal_warn_src_t warn_src_i,
  input wire logic [15:0]    general_code_i,
  input wire logic           fault_clear_command_i,
  input wire wlal_chan_t     fault_clear_chan_i,
  input wire wlal_req_t      req_i,
  input wire wlal_rsp_t      rsp_o,
  input wire logic [15:0]    latched_warning_word_o,
  input wire logic [15:0]    last_warning_code_o,
  input wire logic           channel_lock_o
);
  logic blk_wr;
  logic lk_wr;
  // write attempts seen from a blocked channel and from the master
  assign blk_wr = req_i.valid && req_i.write && req_i.chan != WLAL_CH_FIELDBUS && channel_lock_o;
  assign lk_wr = req_i.valid && req_i.write && !req_i.chan && req_i.addr == ADDR_LOCK;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  rsvd_zero_a: assert property ((latched_warning_word_o & RESERVED_MASK) == 16'h0000)
    else $error("reserved bit set");
  rsp_lag_a: assert property (!$past(srst_i) |-> rsp_o.valid == $past(req_i.valid))
    else $error("answer timing");
  blocked_wr_a: assert property (blk_wr |=> rsp_o.refused && channel_lock_o)
    else $error("blocked write taken");
  lock_wr_a: assert property (lk_wr && req_i.wdata < 16'h0002
    |=> channel_lock_o == $past(req_i.wdata[0])) else $error("lock not written");
  general_a: assert property (warn_src_i.general |=> latched_warning_word_o[0]
    && last_warning_code_o == $past(general_code_i)) else $error("general warning lost");
  sticky_a: assert property (latched_warning_word_o[1] && !fault_clear_command_i
    |=> latched_warning_word_o[1]) else $error("flag dropped");
  clear_all_a: assert property (fault_clear_command_i && !fault_clear_chan_i
    && warn_src_i == '0 |=> latched_warning_word_o == 16'h0000) else $error("clear failed");
  supply_drop_a: assert property (!(warn_src_i.undervolt || warn_src_i.phase_loss) [*2]
    |=> !latched_warning_word_o[BIT_SUPPLY]) else $error("no self clear");
endmodule

bind wlal_top wlal_chk u_chk (.*);

//--- dv/wlal_host.sv
`timescale 1ns/1ps
module wlal_host
  import wlal_pkg::*;
(
  input  wire logic      clk_i,
  input  wire wlal_rsp_t rsp_i,
  output wlal_req_t      req_o
);
  initial req_o = '0;
  // any channel asks; only the master may shut out the rest
  task automatic acc(wlal_chan_t ch, logic wr, logic [15:0] ad, logic [15:0] wd,
                     output wlal_rsp_t rs);
    @(negedge clk_i);
    req_o = {1'b1, ch, wr, ad, wd};
    @(posedge clk_i);
    #1;
    rs = rsp_i;
    // released lines show inverted stale data, never a frozen copy
    req_o = {1'b0, ~ch, ~wr, ~ad, ~wd};
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  import wlal_pkg::*;
  logic           clk_i = 1'b0;
  logic           srst_i = 1'b1;
  wlal_warn_src_t warn_src_i = '0;
  logic [15:0]    general_code_i = 16'h0000;
  wlal_mode_t     mode_i = WLAL_MODE_POSITION;
  logic           fault_clear_command_i = 1'b0;
  wlal_chan_t     fault_clear_chan_i = WLAL_CH_FIELDBUS;
  logic           stop_i = 1'b0;
  wlal_req_t      req_i;
  wlal_rsp_t      rsp_o;
  logic           stop_o, channel_lock_o, stop_e, lock_e, fc;
  logic [15:0]    active_warning_word_o, latched_warning_word_o, last_warning_code_o;
  logic [15:0]    act_e, lat_e, code_e;
  int             seed = 38170;
  int             mismatches = 0;
  int             checked = 0;

  wlal_top  i_dut (.*);
  wlal_host i_host (.clk_i(clk_i), .rsp_i(rsp_o), .req_o(req_i));

  initial forever #25 clk_i = ~clk_i;

  // bit map; position detection only counts in position mode
  function automatic logic [15:0] wmap(wlal_warn_src_t s, wlal_mode_t m);
    wmap = {2'h0, s.pos_pending && m == WLAL_MODE_POSITION, s.fieldbus2,
      s.undervolt | s.phase_loss, s.power_stage_ready_a | s.power_stage_ready_b, s.rs485,
      s.encoder, s.can, s.brake_ovl, s.motor_ovl, s.stage_ovl, 1'b0, s.motor_temp,
      s.stage_temp, s.general};
  endfunction

  // reference model; a clear from a shut out channel does nothing
  assign fc = fault_clear_command_i && (!fault_clear_chan_i || !lock_e);
  always @(posedge clk_i) begin
    if (srst_i) begin
      {act_e, lat_e, code_e, stop_e, lock_e} <= '0;
    end else begin
      act_e <= wmap(warn_src_i, mode_i);
      lat_e <= wmap(warn_src_i, mode_i) | (fc ? 16'h0000 : lat_e & (~AUTO_CLR_MASK | act_e));
      stop_e <= stop_i;
      if (warn_src_i.general) code_e <= general_code_i;
      if (req_i.valid && req_i.write && !req_i.chan && req_i.addr == ADDR_LOCK
          && req_i.wdata < 16'h0002) lock_e <= req_i.wdata[0];
    end
  end

  task automatic chk(logic [49:0] got, logic [49:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one register access, answer flags and read data compared together
  task automatic bus(wlal_chan_t ch, logic wr, logic [15:0] ad, wd, ex, logic [2:0] fl);
    wlal_rsp_t rs;
    i_host.acc(ch, wr, ad, wd, rs);
    chk(50'(rs), 50'({fl, ex}));
  endtask

  // random warning traffic; msk thins the sources out
  task automatic tick(int n, logic [14:0] msk);
    repeat (n) begin
      @(negedge clk_i);
      warn_src_i = msk & 15'($random(seed)) & 15'($random(seed));
      mode_i = wlal_mode_t'(2'($random(seed)));
      general_code_i = 16'($random(seed));
      fault_clear_command_i = 3'($random(seed)) == 3'h0;
      fault_clear_chan_i = wlal_chan_t'(2'($random(seed)));
      stop_i = 1'($random(seed));
      @(posedge clk_i);
      #1;
      chk({active_warning_word_o, latched_warning_word_o, last_warning_code_o, stop_o,
        channel_lock_o}, {act_e, lat_e, code_e, stop_e, lock_e});
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the length of the run
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    bus(WLAL_CH_TOOL, 1'b0, ADDR_LOCK, 16'h0000, 16'h0000, 3'h4);
    tick(300, '1);
    tick(30, '0);
    bus(WLAL_CH_FIELDBUS, 1'b1, ADDR_LOCK, 16'h0001, 16'h0000, 3'h4);
    for (int c = 1; c < 4; c++) begin
      bus(wlal_chan_t'(c), 1'b1, ADDR_LOCK, 16'h0000, 16'h0000, 3'h6);
      bus(wlal_chan_t'(c), 1'b0, ADDR_LOCK, 16'h0000, 16'h0001, 3'h4);
    end
    bus(WLAL_CH_FIELDBUS, 1'b1, ADDR_LOCK, 16'h0002, 16'h0000, 3'h5);
    bus(WLAL_CH_FIELDBUS, 1'b0, 16'h0002, 16'h0000, 16'h0000, 3'h5);
    tick(300, '1);
    tick(4, '0);
    @(negedge clk_i);
    fault_clear_command_i = 1'b0;
    bus(WLAL_CH_PANEL, 1'b0, ADDR_LATCHED, 16'h0000, lat_e, 3'h4);
    bus(WLAL_CH_PANEL, 1'b0, ADDR_ACTIVE, 16'h0000, 16'h0000, 3'h4);
    bus(WLAL_CH_FIELDBUS, 1'b1, ADDR_LOCK, 16'h0000, 16'h0000, 3'h4);
    // corner: master clear with every source quiet empties the whole word
    @(negedge clk_i);
    warn_src_i = '0;
    fault_clear_command_i = 1'b1;
    fault_clear_chan_i = WLAL_CH_FIELDBUS;
    @(posedge clk_i);
    #1;
    chk(50'(latched_warning_word_o), 50'(16'h0000));
    @(negedge clk_i);
    fault_clear_command_i = 1'b0;
    tick(200, '1);
    finish_test();
  end
endmodule
